// *** hdl/ebtc_map.svh ***
`ifndef EBTC_MAP_SVH
`define EBTC_MAP_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses on the apb bus)
// ----------------------------------------------------------------
`define EBTC_CNT_OFF 8'h00
`define EBTC_CTL_OFF 8'h04
`define EBTC_ICR_OFF 8'h08

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define EBTC_CTL_CS_BIT 5
`define EBTC_CTL_SE_BIT 4
`define EBTC_CTL_PSA_BIT 3
`define EBTC_CTL_PS_MSB 2
`define EBTC_ICR_GIE_BIT 7
`define EBTC_ICR_OIE_BIT 5
`define EBTC_ICR_FLAG_BIT 2

// ----------------------------------------------------------------
// reset values, widths and counts
// ----------------------------------------------------------------
`define EBTC_CTL_RST 8'h3F
`define EBTC_ICR_RST 8'h00
`define EBTC_CNT_RST 8'h00
`define EBTC_CNT_MAX 8'hFF
`define EBTC_INHIBIT_CYC 2'h2
`define EBTC_PRE_W 8

`endif

// *** hdl/ebtc_pkg.sv ***
`include "ebtc_map.svh"

package ebtc_pkg;

  // ----------------------------------------------------------------
  // state of the counter block
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] count;
    logic [1:0] inhibit;
    logic cs;
    logic se;
    logic psa;
    logic [2:0] ps;
    logic global_irq_enable;
    logic oie;
    logic flag;
    logic pin_q;
    logic [31:0] rdata;
  } ebtc_state_t;

  // ----------------------------------------------------------------
  // state of the shared prescaler
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [`EBTC_PRE_W-1:0] cnt;
  } ebtc_pre_state_t;

endpackage

// *** hdl/ebtc_prescaler.sv ***
`include "ebtc_map.svh"

module ebtc_prescaler
  import ebtc_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // tick path
  input wire logic tick_in,
  input wire logic clear,
  input wire logic [3:0] shift,
  output logic tick_out
);

  ebtc_pre_state_t st_q;
  ebtc_pre_state_t st_d;
  logic [`EBTC_PRE_W-1:0] mask;

  // low bits that must all be ones for a divided tick
  function automatic logic [`EBTC_PRE_W-1:0] ratio_mask(
    input logic [3:0] sh);
    logic [`EBTC_PRE_W:0] m;
    m = ({{`EBTC_PRE_W{1'b0}}, 1'b1} << sh) - {{`EBTC_PRE_W{1'b0}}, 1'b1};
    return m[`EBTC_PRE_W-1:0];
  endfunction

  // shift of zero gives a mask of zero, so ticks pass straight through
  always_comb begin
    mask = ratio_mask(shift);
    tick_out = tick_in && ((st_q.cnt & mask) == mask);
    st_d = st_q;
    if (clear) begin
      st_d.cnt = '0;
    end else if (tick_in) begin
      st_d.cnt = st_q.cnt + {{(`EBTC_PRE_W-1){1'b0}}, 1'b1};
    end
  end

  // internal count is never visible to software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  pass_through_a: assert property (
    (shift == 4'h0) |-> (tick_out == tick_in))
    else $error("prescaler did not pass ticks at ratio one");

  div_two_a: assert property (
    (shift == 4'h1) && tick_out && !clear ##1 (shift == 4'h1)
      |-> !tick_out)
    else $error("prescaler gave two ticks in a row at ratio two");

endmodule

// *** hdl/ebtc_top.sv ***
// What this block does
// - timer mode counts every instruction cycle when the prescaler serves the watchdog
// - count write blocks increments two cycles
// - counter mode counts external pin edges
// - edge select: clear rising, set falling
// - one prescaler, counter or watchdog, hidden
// - wrap from ff to 00 sets flag
// - overflow enable clear masks the request
// - no counting while asleep
// - flag sets regardless of enable bits
// - global enable gates every request

`include "ebtc_map.svh"

module ebtc_top
  import ebtc_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // count source and power state
  input wire logic external_count_pin,
  input wire logic sleep_mode,
  // watchdog side of the shared prescaler
  input wire logic watchdog_raw_tick,
  output logic watchdog_scaled_tick,
  // request towards the processor
  output logic irq_req
);

  // ----------------------------------------------------------------
  // reset image of the state
  // ----------------------------------------------------------------
  localparam logic [7:0] CTL_RST = `EBTC_CTL_RST;
  localparam logic [7:0] ICR_RST = `EBTC_ICR_RST;

  ebtc_state_t st_q;
  ebtc_state_t st_d;
  logic wr_acc;
  logic rd_setup;
  logic wr_cnt;
  logic wr_ctl;
  logic wr_icr;
  logic src_edge;
  logic timer_src;
  logic pre_in;
  logic pre_out;
  logic pre_clear;
  logic [3:0] pre_shift;
  logic timer_tick;
  logic cnt_tick;
  logic ovf;
  logic [31:0] rd_val;

  // address decode for the error answer; the read mux decodes with its own case
  function automatic logic is_mapped(input logic [7:0] a);
    return (a == `EBTC_CNT_OFF) || (a == `EBTC_CTL_OFF) ||
           (a == `EBTC_ICR_OFF);
  endfunction

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  // zero wait states: a write lands on the access edge
  assign wr_acc = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign wr_cnt = wr_acc && (paddr == `EBTC_CNT_OFF);
  assign wr_ctl = wr_acc && (paddr == `EBTC_CTL_OFF);
  assign wr_icr = wr_acc && (paddr == `EBTC_ICR_OFF);

  // ----------------------------------------------------------------
  // count source selection
  // ----------------------------------------------------------------
  // edge polarity
  assign src_edge = st_q.se ? (st_q.pin_q && !external_count_pin)
                            : (!st_q.pin_q && external_count_pin);

  assign timer_src = (st_q.cs ? src_edge : 1'b1) && !sleep_mode;

  // prescaler steering
  // the timer ratio starts at two, the watchdog ratio at one
  assign pre_in = st_q.psa ? watchdog_raw_tick : timer_src;
  assign pre_shift = st_q.psa ? {1'b0, st_q.ps}
                              : ({1'b0, st_q.ps} + 4'h1);
  // a count write restarts the prescaler when it serves the counter
  assign pre_clear = wr_cnt && !st_q.psa;

  ebtc_prescaler u_pre (
    .pclk(pclk),
    .presetn(presetn),
    .tick_in(pre_in),
    .clear(pre_clear),
    .shift(pre_shift),
    .tick_out(pre_out)
  );

  // the party without the prescaler sees its raw ticks
  assign timer_tick = st_q.psa ? timer_src : pre_out;
  assign watchdog_scaled_tick = st_q.psa ? pre_out : watchdog_raw_tick;

  assign cnt_tick = timer_tick && (st_q.inhibit == 2'h0);
  assign ovf = cnt_tick && (st_q.count == `EBTC_CNT_MAX);

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  // count, control and interrupt readback
  always_comb begin
    rd_val = 32'h0000_0000;
    case (paddr)
      `EBTC_CNT_OFF: rd_val[7:0] = st_q.count;
      `EBTC_CTL_OFF: begin
        rd_val[`EBTC_CTL_CS_BIT] = st_q.cs;
        rd_val[`EBTC_CTL_SE_BIT] = st_q.se;
        rd_val[`EBTC_CTL_PSA_BIT] = st_q.psa;
        rd_val[`EBTC_CTL_PS_MSB:0] = st_q.ps;
      end
      `EBTC_ICR_OFF: begin
        rd_val[`EBTC_ICR_GIE_BIT] = st_q.global_irq_enable;
        rd_val[`EBTC_ICR_OIE_BIT] = st_q.oie;
        rd_val[`EBTC_ICR_FLAG_BIT] = st_q.flag;
      end
      default: rd_val = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    st_d.pin_q = external_count_pin;
    if (st_q.inhibit != 2'h0) begin
      st_d.inhibit = st_q.inhibit - 2'h1;
    end
    if (cnt_tick) begin
      st_d.count = st_q.count + 8'h01;
    end
    if (wr_cnt) begin
      st_d.count = pwdata[7:0];
      st_d.inhibit = `EBTC_INHIBIT_CYC;
    end
    if (wr_ctl) begin
      st_d.cs = pwdata[`EBTC_CTL_CS_BIT];
      st_d.se = pwdata[`EBTC_CTL_SE_BIT];
      st_d.psa = pwdata[`EBTC_CTL_PSA_BIT];
      st_d.ps = pwdata[`EBTC_CTL_PS_MSB:0];
    end
    if (wr_icr) begin
      st_d.global_irq_enable = pwdata[`EBTC_ICR_GIE_BIT];
      st_d.oie = pwdata[`EBTC_ICR_OIE_BIT];
      st_d.flag = pwdata[`EBTC_ICR_FLAG_BIT];
    end
    // set ignores enables
    // placed last so a same-cycle software clear cannot lose the event
    if (ovf) begin
      st_d.flag = 1'b1;
    end
    // read data captured in setup, held through the access cycle
    if (rd_setup) begin
      st_d.rdata = rd_val;
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '{
        count: `EBTC_CNT_RST,
        inhibit: 2'h0,
        cs: CTL_RST[`EBTC_CTL_CS_BIT],
        se: CTL_RST[`EBTC_CTL_SE_BIT],
        psa: CTL_RST[`EBTC_CTL_PSA_BIT],
        ps: CTL_RST[`EBTC_CTL_PS_MSB:0],
        global_irq_enable: ICR_RST[`EBTC_ICR_GIE_BIT],
        oie: ICR_RST[`EBTC_ICR_OIE_BIT],
        flag: ICR_RST[`EBTC_ICR_FLAG_BIT],
        pin_q: 1'b0,
        rdata: 32'h0000_0000
      };
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign prdata = st_q.rdata;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !is_mapped(paddr);
  // the flag stays until software writes it back to zero
  assign irq_req = st_q.global_irq_enable && st_q.oie && st_q.flag;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  timer_increment_a: assert property (
    !st_q.cs && st_q.psa && !sleep_mode && (st_q.inhibit == 2'h0) &&
      !wr_cnt |=> (st_q.count == $past(st_q.count) + 8'h01))
    else $error("timer mode missed an instruction cycle increment");

  write_inhibit_a: assert property (
    wr_cnt |=> (st_q.count == $past(pwdata[7:0])) ##1 $stable(st_q.count))
    else $error("count moved in first cycle after a write");

  inhibit_second_a: assert property (
    wr_cnt ##2 !wr_cnt |=> $stable(st_q.count))
    else $error("count moved in second cycle after a write");

  edge_count_a: assert property (
    st_q.cs && st_q.psa && src_edge && !sleep_mode &&
      (st_q.inhibit == 2'h0) && !wr_cnt
      |=> (st_q.count == $past(st_q.count) + 8'h01))
    else $error("counter mode missed a pin edge");

  edge_polarity_a: assert property (
    st_q.cs && st_q.psa && !wr_cnt && !src_edge |=> $stable(st_q.count))
    else $error("counter moved without the selected edge");

  share_excl_a: assert property (
    st_q.psa |-> (watchdog_scaled_tick == pre_out) &&
      (timer_tick == timer_src))
    else $error("prescaler served both users at once");

  overflow_flag_a: assert property (
    ovf |=> st_q.flag && (st_q.count == 8'h00 || $past(wr_cnt)))
    else $error("wrap did not set the overflow flag");

  irq_gate_a: assert property (
    (!st_q.oie || !st_q.global_irq_enable) |-> !irq_req)
    else $error("request raised while masked");

  sleep_hold_a: assert property (
    sleep_mode && !wr_cnt |=> $stable(st_q.count))
    else $error("count moved during sleep");

  flag_set_wins_a: assert property (
    ovf && wr_icr && !pwdata[`EBTC_ICR_FLAG_BIT] |=> st_q.flag)
    else $error("overflow lost against a software clear");

  read_back_a: assert property (
    rd_setup && (paddr == `EBTC_CNT_OFF) ##1 psel && penable
      |-> (prdata[7:0] == $past(st_q.count)) && (prdata[31:8] == 24'h0))
    else $error("count read returned a wrong value");

  cov_overflow: cover property (ovf ##1 irq_req);
  cov_edge_count: cover property (st_q.cs && cnt_tick);
  cov_inhibit: cover property (wr_cnt ##1 timer_tick);
  cov_prescaled: cover property (!st_q.psa && pre_out);

endmodule

// *** tb/ebtc_pin_model.sv ***
// ----------------------------------------------------------------
// external clock source on the count input
// ----------------------------------------------------------------
module ebtc_pin_model (
  // clock
  input wire logic pclk,
  // count input towards the block
  output logic pin
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle low so that enabling a mode never shows a false edge
  initial pin = 1'b0;

  // n full pulses, each level held for half cycles (1 = fast)
  task automatic gen(input int n, input int half);
    repeat (n) begin
      repeat (half) @(posedge pclk);
      pin <= 1'b1;
      repeat (half) @(posedge pclk);
      pin <= 1'b0;
    end
    repeat (half) @(posedge pclk);
  endtask
endmodule

// *** tb/ebtc_tb_top.sv ***
`include "ebtc_map.svh"

module ebtc_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic pclk, presetn, psel, penable, pwrite, sleep_mode, wd_raw;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, v, k;
  logic pready, pslverr, pin, wd_scaled, irq_req, er;
  int num_errors, n_tests;
  logic [7:0] cfg [4] = '{8'h08, 8'h00, 8'h01, 8'h02};
  logic [31:0] span [4] = '{32'h20, 32'h10, 32'h8, 32'h4};

  // 4 ns clock
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  ebtc_top u_ebtc_top (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .external_count_pin(pin),
    .sleep_mode(sleep_mode), .watchdog_raw_tick(wd_raw),
    .watchdog_scaled_tick(wd_scaled), .irq_req(irq_req));

  ebtc_pin_model u_ebtc_pin_model (.pclk(pclk), .pin(pin));

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk32(input string nm, input logic [31:0] e, g);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk1(input string nm, input logic e, g);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s expected %b seen %b", nm, e, g);
    end
  endtask

  // one transfer plus an idle edge, so psel never changes twice at once
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no wait limit here: only the bench watchdog ends a stuck transfer
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e,
                       input string nm);
    apb(1'b0, a, 32'h0);
    chk32(nm, e, rd);
  endtask

  task automatic summarize;
    $display("checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    sleep_mode = 1'b0;
    wd_raw = 1'b0;
    num_errors = 0;
    n_tests = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdchk(`EBTC_CNT_OFF, 32'h00, "cnt_rst");
    rdchk(`EBTC_CTL_OFF, 32'h3F, "ctl_rst");
    rdchk(`EBTC_ICR_OFF, 32'h00, "icr_rst");
    // unmapped place: refused, no side effect
    apb(1'b1, 8'h0C, 32'h0);
    chk1("wr_err", 1'b1, er);
    apb(1'b0, 8'h0C, 32'h0);
    chk1("rd_err", 1'b1, er);
    chk32("rd_unmapped", 32'h0, rd);
    rdchk(`EBTC_CTL_OFF, 32'h3F, "ctl_keep");
    // count growth over 32 cycles, clear of the write inhibit
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, `EBTC_CTL_OFF, {24'h0, cfg[i]});
      apb(1'b1, `EBTC_CNT_OFF, 32'h0);
      repeat (4) @(posedge pclk);
      apb(1'b0, `EBTC_CNT_OFF, 32'h0);
      v = rd;
      repeat (29) @(posedge pclk);
      apb(1'b0, `EBTC_CNT_OFF, 32'h0);
      chk32("span", span[i], rd - v);
    end
    // reads three cycles apart after a count write
    apb(1'b1, `EBTC_CTL_OFF, 32'h08);
    apb(1'b1, `EBTC_CNT_OFF, 32'h10);
    rdchk(`EBTC_CNT_OFF, 32'h10, "inh_a");
    rdchk(`EBTC_CNT_OFF, 32'h12, "inh_b");
    sleep_mode <= 1'b1;
    apb(1'b1, `EBTC_CNT_OFF, 32'h40);
    repeat (10) @(posedge pclk);
    rdchk(`EBTC_CNT_OFF, 32'h40, "sleep_t");
    sleep_mode <= 1'b0;
    // overflow with every enable clear, then the enable combinations
    // a flag clear whose access edge is the wrap edge: the set wins
    apb(1'b1, `EBTC_CNT_OFF, 32'hFE);
    @(posedge pclk);
    apb(1'b1, `EBTC_ICR_OFF, 32'h0);
    rdchk(`EBTC_ICR_OFF, 32'h04, "flag_off");
    chk1("irq_off", 1'b0, irq_req);
    apb(1'b1, `EBTC_ICR_OFF, 32'hFFFFFFFF);
    rdchk(`EBTC_ICR_OFF, 32'hA4, "icr_all");
    chk1("irq_on", 1'b1, irq_req);
    apb(1'b1, `EBTC_ICR_OFF, 32'h24);
    chk1("irq_gie", 1'b0, irq_req);
    apb(1'b1, `EBTC_ICR_OFF, 32'h84);
    chk1("irq_oie", 1'b0, irq_req);
    apb(1'b1, `EBTC_ICR_OFF, 32'hA0);
    chk1("irq_clr", 1'b0, irq_req);
    rdchk(`EBTC_ICR_OFF, 32'hA0, "flag_clr");
    apb(1'b1, `EBTC_ICR_OFF, 32'h0);
    // external edges, slow rising then fast falling, then asleep
    apb(1'b1, `EBTC_CTL_OFF, 32'h28);
    apb(1'b1, `EBTC_CNT_OFF, 32'h0);
    u_ebtc_pin_model.gen(3, 2);
    rdchk(`EBTC_CNT_OFF, 32'h03, "rise");
    apb(1'b1, `EBTC_CTL_OFF, 32'h38);
    apb(1'b1, `EBTC_CNT_OFF, 32'h0);
    u_ebtc_pin_model.gen(5, 1);
    rdchk(`EBTC_CNT_OFF, 32'h05, "fall");
    sleep_mode <= 1'b1;
    u_ebtc_pin_model.gen(4, 3);
    rdchk(`EBTC_CNT_OFF, 32'h05, "sleep_c");
    sleep_mode <= 1'b0;
    // watchdog owns the prescaler at ratio 2
    apb(1'b1, `EBTC_CTL_OFF, 32'h09);
    k = 32'h0;
    repeat (8) begin
      wd_raw <= 1'b1;
      @(posedge pclk);
      if (wd_scaled === 1'b1) k = k + 32'h1;
      wd_raw <= 1'b0;
      @(posedge pclk);
    end
    chk32("wd_ticks", 32'h4, k);
    summarize();
  end

  // hang guard, far beyond the few hundred cycles the tests need
  initial begin
    repeat (5000) @(posedge pclk);
    num_errors++;
    summarize();
  end
endmodule
